// File: bench/fan_coil_local_test_sequencer_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "fcl_defines.svh"
module fan_coil_local_test_sequencer_bench
  import fcl_pkg::*;
;
  localparam int TICK = 10;    // Short tick keeps the run brief
  localparam int HOLD = 5;     // Entry hold in ticks
  localparam int IDLE = 1300;  // Timeout longer than the fan speed I lamp pattern
  localparam int SLOT = `FCL_SLOT_MS * TICK;
  localparam int BUS_ON = `FCL_BUS_ON_MS * TICK;

  logic       mclk;         // System clock
  logic       rst_n;        // Reset, active low
  logic       learn;        // Learning button pin
  logic       bus_ok;       // Bus status pin
  logic       button;       // Test button pin from the panel
  logic       lamp;         // Status lamp
  fcl_relay_t relay;        // Relay drive
  logic       test_active;  // Test mode flag
  int         fails;        // Mismatches
  int         n_checks;     // Comparisons made

  fcl_seq #(.TICK_CYC(TICK), .HOLD_MS(HOLD), .IDLE_MS(IDLE), .DEB_MS(2)) dut (
    .mclk                  (mclk),
    .rst_n                 (rst_n),
    .local_test_pushbutton (button),
    .learning_pushbutton   (learn),
    .bus_operational       (bus_ok),
    .status_lamp           (lamp),
    .relay_out             (relay),
    .test_active           (test_active)
  );

  fcl_panel_model panel (
    .mclk        (mclk),
    .status_lamp (lamp),
    .relay_out   (relay),
    .button      (button)
  );

  // Free-running clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Bounded wait for a relay pattern
  task automatic wait_relay(input fcl_relay_t exp);
    for (int i = 0; i < 300 && relay !== exp; i++)
      @(posedge mclk);
    check("relay", {1'b0, relay}, {1'b0, exp});
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Learning button toggles the addressing lamp
  task automatic t_learn();
    for (int k = 0; k < 2; k++)
    begin
      @(posedge mclk);
      learn <= 1'b1;
      repeat (60) @(posedge mclk);
      learn <= 1'b0;
      repeat (60) @(posedge mclk);
      check("lamp", {7'h00, lamp}, (k == 0) ? 8'h01 : 8'h00);
    end
  endtask

  // Short hold is refused, long hold enters at fan speed I with one flash
  task automatic t_entry();
    int r0;
    panel.push(3 * TICK, 2);
    repeat (100) @(posedge mclk);
    check("test_active", {7'h00, test_active}, 8'h00);
    r0 = panel.rise_cnt;
    panel.push(HOLD * TICK + 100, 2);
    check("relay", {1'b0, relay}, 8'h01);
    check("test_active", {7'h00, test_active}, 8'h01);
    repeat (3 * SLOT - 300) @(posedge mclk);
    check("flashes", 8'(panel.rise_cnt - r0), 8'h01);
  endtask

  // Speed II, relay stands, timer restarted by the press
  task automatic t_step_two();
    panel.push(40, 3);
    wait_relay(7'h02);
    repeat (IDLE * TICK - 5000) @(posedge mclk);
    check("test_active", {7'h00, test_active}, 8'h01);
    check("relay", {1'b0, relay}, 8'h02);
  endtask

  // Remaining steps in order, then wrap to the first
  task automatic t_rest();
    for (int n = 2; n < 8; n++)
    begin
      panel.push(40, 1);
      wait_relay(7'(1 << (n % 7)));
    end
    check("clash", 8'(panel.clash_cnt), 8'h00);
  endtask

  // Inactivity leaves test mode, re-entry restarts at step one
  task automatic t_timeout();
    repeat (IDLE * TICK - 1000) @(posedge mclk);
    check("test_active", {7'h00, test_active}, 8'h01);
    for (int i = 0; i < 2000 && test_active !== 1'b0; i++)
      @(posedge mclk);
    check("test_active", {7'h00, test_active}, 8'h00);
    check("relay", {1'b0, relay}, 8'h00);
    panel.push(HOLD * TICK + 100, 0);
    check("relay", {1'b0, relay}, 8'h01);
  endtask

  // Bus down flashes the lamp at the slow rate; the measured phase falls after test mode has timed out
  task automatic t_bus_down();
    int r0;
    int run;
    @(posedge mclk);
    bus_ok <= 1'b0;
    repeat (100) @(posedge mclk);
    // Skip a partly elapsed on phase, then measure one whole one
    for (int i = 0; i < 20000 && lamp !== 1'b0; i++)
      @(posedge mclk);
    r0 = panel.rise_cnt;
    for (int i = 0; i < 20000 && panel.rise_cnt == r0; i++)
      @(posedge mclk);
    run = 0;
    while (lamp === 1'b1 && run < 20000)
    begin
      @(posedge mclk);
      run++;
    end
    check("bus_flash", {7'h00, run > BUS_ON - 70 && run < BUS_ON + 70}, 8'h01);
  endtask

  // Main sequence
  initial
  begin
    fails = 0;
    n_checks = 0;
    rst_n = 1'b0;
    learn = 1'b0;
    bus_ok = 1'b1;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    check("lamp", {7'h00, lamp}, 8'h00);
    check("relay", {1'b0, relay}, 8'h00);
    t_learn();
    t_entry();
    t_step_two();
    t_rest();
    t_timeout();
    t_bus_down();
    conclude();
  end

  // Watchdog beyond the longest expected run
  initial
  begin
    repeat (99000) @(posedge mclk);
    fails++;
    conclude();
  end
endmodule
`default_nettype wire

// File: bench/fcl_panel_model.sv
`timescale 1ns/1ns
`default_nettype none
module fcl_panel_model
  import fcl_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       status_lamp,
  input  wire fcl_relay_t relay_out,
  output var  logic       button
);
  int   clash_cnt;  // Cycles with two fan speeds closed
  int   rise_cnt;   // Lamp turn-on events seen
  logic lamp_q;     // Lamp level one cycle ago

  initial
  begin
    button = 1'b0;
    clash_cnt = 0;
    rise_cnt = 0;
    lamp_q = 1'b0;
  end

  // Watch the relays and the lamp like the wiring would
  always @(posedge mclk)
  begin
    if ((relay_out.fan & (relay_out.fan - 3'h1)) != 3'h0)
      clash_cnt <= clash_cnt + 1;
    if (status_lamp === 1'b1 && lamp_q !== 1'b1)
      rise_cnt <= rise_cnt + 1;
    lamp_q <= status_lamp;
  end

  // Contact chatter first, far shorter than a debounce span, then a clean hold
  task automatic push(input int hold_cyc, input int bounces);
    for (int i = 0; i < 2 * bounces; i++)
    begin
      repeat (3) @(posedge mclk);
      button <= ~button;
    end
    @(posedge mclk);
    button <= 1'b1;
    repeat (hold_cyc) @(posedge mclk);
    button <= 1'b0;
    // Released gap long enough for the release to be debounced
    repeat (60) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// File: verilog/fcl_debounce.sv
`timescale 1ns/1ns
`default_nettype none
`include "fcl_defines.svh"
module fcl_debounce
  import fcl_pkg::*;
#(
  parameter int DEB_MS   = `FCL_DEB_MS,
  parameter bit IDLE_LVL = 1'b0   // Level the pin rests at; avoids a false edge after reset
)(
  input  wire logic mclk,
  input  wire logic rst_sync_n,
  input  wire logic tick,
  input  wire logic pin,
  output var  logic level,
  output var  logic press
);
  logic        s1_ff;       // First sync stage, read only by s2_ff
  logic        s2_ff;       // Second sync stage
  logic        s3_ff;       // Third sync stage
  logic [15:0] stab_ff;     // Milliseconds the synced value has held
  logic [15:0] nxt_stab;
  logic        level_ff;    // Debounced level
  logic        nxt_level;
  logic        press_ff;    // One-cycle pulse on a debounced rise
  logic        nxt_press;

  // The stability counter is 16 bits wide and needs at least one tick
  if (DEB_MS < 1 || DEB_MS > 65535)
  begin : g_chk
    $error("fcl_debounce: DEB_MS out of range");
  end

  // Three-stage synchroniser for an asynchronous pin
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      s1_ff <= IDLE_LVL;
      s2_ff <= IDLE_LVL;
      s3_ff <= IDLE_LVL;
    end
    else
    begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Accept a change only after it has held steady; contact bounce
  // shorter than the window never reaches the sequencer
  always_comb
  begin
    nxt_stab  = stab_ff;
    nxt_level = level_ff;
    nxt_press = 1'b0;
    if (s2_ff == level_ff || s2_ff != s3_ff)
      nxt_stab = 16'h0000;
    else if (tick)
    begin
      if (stab_ff == 16'(DEB_MS - 1))
      begin
        nxt_level = s3_ff;
        nxt_press = s3_ff;
        nxt_stab  = 16'h0000;
      end
      else
        nxt_stab = stab_ff + 16'h0001;
    end
  end

  // Register the filter state
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      stab_ff  <= 16'h0000;
      level_ff <= IDLE_LVL;
      press_ff <= 1'b0;
    end
    else
    begin
      stab_ff  <= nxt_stab;
      level_ff <= nxt_level;
      press_ff <= nxt_press;
    end
  end

  assign level = level_ff;
  assign press = press_ff;
endmodule
`default_nettype wire

// File: verilog/fcl_defines.svh
`ifndef FCL_DEFINES_SVH
`define FCL_DEFINES_SVH
// Base timing, in nanoseconds
`define FCL_CLK_NS        32'h0000000A
`define FCL_TICK_NS       32'h000F4240
// Times in milliseconds, counted on the 1 ms tick
`define FCL_HOLD_MS       16'h0FA0
`define FCL_IDLE_MS       16'hEA60
`define FCL_DEB_MS        16'h0014
`define FCL_BUS_PERIOD_MS 16'h0D05
`define FCL_BUS_ON_MS     16'h0683
`define FCL_SLOT_MS       16'h0190
`define FCL_FLASH_ON_MS   16'h00C8
// Sequence layout
`define FCL_N_STEPS       3'h7
`define FCL_N_FAN         3'h3
`endif

// File: verilog/fcl_pkg.sv
package fcl_pkg;
  // Operating mode of the sequencer
  typedef enum logic [0:0] {FCL_NORMAL, FCL_TEST} fcl_mode_t;
  // Relay drive: three fan speeds and four further test outputs
  typedef struct packed {
    logic [3:0] aux;
    logic [2:0] fan;
  } fcl_relay_t;
endpackage

// File: verilog/fcl_seq.sv
// Notes on behaviour
// - Lamp dark normally, steady addressing, flashing test.
// - Learning press toggles normal and addressing mode.
// - Bus down flashes lamp at about 0.3 Hz.
// - First test function reports bus state.
// - Enter test only after 4 s hold.
// - Each press in test advances one step.
// - Lamp pattern on press identifies active step.
// - First step switches fan speed I on.
// - Step output stays on until next press.
// - One minute without press returns to normal.
// - Re-entry needs 4 s hold, restarts step one.
// - Second step switches fan speed II on.
// - Steps never skipped, always strictly in order.
// - Test works with or without loaded program.
// - Never two fan speeds closed together.
// - Seven output functions stepped in fixed order.
`timescale 1ns/1ns
`default_nettype none
`include "fcl_defines.svh"
module fcl_seq
  import fcl_pkg::*;
#(
  parameter int TICK_CYC = `FCL_TICK_NS / `FCL_CLK_NS,
  parameter int HOLD_MS  = `FCL_HOLD_MS,
  parameter int IDLE_MS  = `FCL_IDLE_MS,
  parameter int DEB_MS   = `FCL_DEB_MS
)(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       local_test_pushbutton,
  input  wire logic       learning_pushbutton,
  input  wire logic       bus_operational,
  output var  logic       status_lamp,
  output var  fcl_relay_t relay_out,
  output var  logic       test_active
);
  localparam int TW = $clog2(TICK_CYC);

  // Refuse settings the counters cannot hold
  if (TICK_CYC < 2 || HOLD_MS < 2 || HOLD_MS > 65535 || IDLE_MS < 2 || IDLE_MS > 65535)
  begin : g_chk
    $error("fcl_seq: timing parameter out of range");
  end

  logic          rst_meta_ff;   // Reset release, first stage
  logic          rst_sync_ff;   // Reset release, used everywhere
  logic [TW-1:0] tick_cnt_ff;   // Divider for the 1 ms enable
  logic [TW-1:0] nxt_tick_cnt;
  logic          tick_ff;       // One-cycle 1 ms enable
  logic          nxt_tick;
  logic          test_lvl;      // Debounced test button level
  logic          test_press;    // Debounced test button press
  logic          learn_press;   // Debounced learning button press
  logic          bus_lvl;       // Debounced bus-healthy level
  fcl_mode_t     mode_ff;       // Normal or test
  fcl_mode_t     nxt_mode;
  logic [2:0]    step_ff;       // Active test step, 0 = fan speed I
  logic [2:0]    nxt_step;
  logic [15:0]   hold_ms_ff;    // Time the test button has been held
  logic [15:0]   nxt_hold_ms;
  logic [15:0]   idle_ms_ff;    // Time since the last test action
  logic [15:0]   nxt_idle_ms;
  logic          addr_ff;       // Addressing mode
  logic          nxt_addr;
  logic [15:0]   slot_ms_ff;    // Position inside a flash slot
  logic [15:0]   nxt_slot_ms;
  logic [3:0]    slot_n_ff;     // Slot index inside a pattern
  logic [3:0]    nxt_slot_n;
  logic [15:0]   bus_ms_ff;     // Position in the bus fault period
  logic [15:0]   nxt_bus_ms;
  logic          lamp_ff;
  logic          nxt_lamp;
  fcl_relay_t    relay_ff;
  fcl_relay_t    nxt_relay;
  logic          enter;         // Long hold completes this cycle

  // Asynchronous assert, synchronous release of reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Millisecond enable; every slower time counts these pulses
  always_comb
  begin
    nxt_tick     = 1'b0;
    nxt_tick_cnt = tick_cnt_ff + TW'(1);
    if (tick_cnt_ff == TW'(TICK_CYC - 1))
    begin
      nxt_tick_cnt = '0;
      nxt_tick     = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end
    else
    begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff     <= nxt_tick;
    end
  end

  // Pushbuttons and bus status arrive from pins
  fcl_debounce #(.DEB_MS(DEB_MS)) u_test_btn (
    .mclk       (mclk),
    .rst_sync_n (rst_sync_ff),
    .tick       (tick_ff),
    .pin        (local_test_pushbutton),
    .level      (test_lvl),
    .press      (test_press)
  );

  fcl_debounce #(.DEB_MS(DEB_MS)) u_learn_btn (
    .mclk       (mclk),
    .rst_sync_n (rst_sync_ff),
    .tick       (tick_ff),
    .pin        (learning_pushbutton),
    .level      (),
    .press      (learn_press)
  );

  // Bus assumed healthy out of reset so the lamp stays dark until a real fault
  fcl_debounce #(.DEB_MS(DEB_MS), .IDLE_LVL(1'b1)) u_bus_ok (
    .mclk       (mclk),
    .rst_sync_n (rst_sync_ff),
    .tick       (tick_ff),
    .pin        (bus_operational),
    .level      (bus_lvl),
    .press      ()
  );

  assign enter = (mode_ff == FCL_NORMAL) && test_lvl && tick_ff
                 && (hold_ms_ff == 16'(HOLD_MS - 1));

  // Mode sequencer; nothing here looks at a loaded program
  always_comb
  begin
    nxt_mode    = mode_ff;
    nxt_step    = step_ff;
    nxt_hold_ms = hold_ms_ff;
    nxt_idle_ms = idle_ms_ff;
    nxt_addr    = addr_ff;
    unique case (mode_ff)
      FCL_NORMAL:
      begin
        if (learn_press)
          nxt_addr = ~addr_ff;
        if (!test_lvl)
          nxt_hold_ms = 16'h0000;                     // Hold must be unbroken
        else if (enter)
        begin
          nxt_mode    = FCL_TEST;
          nxt_step    = 3'h0;                         // Always from fan speed I
          nxt_idle_ms = 16'h0000;
          nxt_hold_ms = 16'h0000;
        end
        else if (tick_ff)
          nxt_hold_ms = hold_ms_ff + 16'h0001;
      end
      FCL_TEST:
      begin
        if (test_press)
        begin
          // One step per press, wrapping after the last
          nxt_step    = (step_ff == `FCL_N_STEPS - 3'h1) ? 3'h0 : step_ff + 3'h1;
          nxt_idle_ms = 16'h0000;
        end
        else if (tick_ff)
        begin
          if (idle_ms_ff == 16'(IDLE_MS - 1))
          begin
            nxt_mode = FCL_NORMAL;
            nxt_step = 3'h0;
          end
          else
            nxt_idle_ms = idle_ms_ff + 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      mode_ff    <= FCL_NORMAL;
      step_ff    <= 3'h0;
      hold_ms_ff <= 16'h0000;
      idle_ms_ff <= 16'h0000;
      addr_ff    <= 1'b0;
    end
    else
    begin
      mode_ff    <= nxt_mode;
      step_ff    <= nxt_step;
      hold_ms_ff <= nxt_hold_ms;
      idle_ms_ff <= nxt_idle_ms;
      addr_ff    <= nxt_addr;
    end
  end

  // Flash timers; a press restarts the pattern of the new step
  always_comb
  begin
    nxt_slot_ms = slot_ms_ff;
    nxt_slot_n  = slot_n_ff;
    nxt_bus_ms  = bus_ms_ff;
    if (tick_ff)
      nxt_bus_ms = (bus_ms_ff == `FCL_BUS_PERIOD_MS - 16'h0001) ? 16'h0000
                   : bus_ms_ff + 16'h0001;
    if (test_press || enter)
    begin
      nxt_slot_ms = 16'h0000;
      nxt_slot_n  = 4'h0;
    end
    else if (tick_ff)
    begin
      if (slot_ms_ff == `FCL_SLOT_MS - 16'h0001)
      begin
        nxt_slot_ms = 16'h0000;
        // Two dark slots close each pattern so the count reads clearly
        nxt_slot_n  = (slot_n_ff == {1'b0, step_ff} + 4'h2) ? 4'h0 : slot_n_ff + 4'h1;
      end
      else
        nxt_slot_ms = slot_ms_ff + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      slot_ms_ff <= 16'h0000;
      slot_n_ff  <= 4'h0;
      bus_ms_ff  <= 16'h0000;
    end
    else
    begin
      slot_ms_ff <= nxt_slot_ms;
      slot_n_ff  <= nxt_slot_n;
      bus_ms_ff  <= nxt_bus_ms;
    end
  end

  // Output decode; one-hot decode of the binary step keeps the fan speeds interlocked
  always_comb
  begin
    nxt_relay = '0;
    nxt_lamp  = 1'b0;
    if (mode_ff == FCL_TEST)
    begin
      if (step_ff < `FCL_N_FAN)
        nxt_relay.fan[step_ff[1:0]] = 1'b1;
      else
        nxt_relay.aux[2'(step_ff - `FCL_N_FAN)] = 1'b1;  // Held until next press
      // Bus fault takes the lamp first so it is the first thing reported
      if (!bus_lvl)
        nxt_lamp = bus_ms_ff < `FCL_BUS_ON_MS;
      else
        nxt_lamp = (slot_n_ff <= {1'b0, step_ff})
                   && (slot_ms_ff < `FCL_FLASH_ON_MS);
    end
    else if (!bus_lvl)
      nxt_lamp = bus_ms_ff < `FCL_BUS_ON_MS;
    else
      nxt_lamp = addr_ff;
  end

  always_ff @(posedge mclk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      lamp_ff     <= 1'b0;
      relay_ff    <= '0;
      test_active <= 1'b0;
    end
    else
    begin
      lamp_ff     <= nxt_lamp;
      relay_ff    <= nxt_relay;
      test_active <= (mode_ff == FCL_TEST);
    end
  end

  assign status_lamp = lamp_ff;
  assign relay_out   = relay_ff;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_sync_ff);

  a_fan_interlock: assert property ($onehot0(relay_out.fan))
    else $error("two fan speeds closed");
  a_lamp_dark: assert property ((mode_ff == FCL_NORMAL && !addr_ff && bus_lvl) |=> !status_lamp)
    else $error("lamp lit in normal mode");
  a_lamp_addr_on: assert property ((mode_ff == FCL_NORMAL && addr_ff && bus_lvl) |=> status_lamp)
    else $error("lamp dark in addressing mode");
  a_addr_toggle: assert property ((mode_ff == FCL_NORMAL && learn_press) |=> addr_ff != $past(addr_ff))
    else $error("learning press did not toggle");
  a_bus_flash: assert property ((mode_ff == FCL_NORMAL && !bus_lvl && bus_ms_ff < `FCL_BUS_ON_MS) |=> status_lamp)
    else $error("bus fault not flashed");
  a_test_bus_report: assert property ((mode_ff == FCL_TEST && !bus_lvl && bus_ms_ff >= `FCL_BUS_ON_MS) |=> !status_lamp)
    else $error("bus fault hidden in test mode");
  a_entry_hold: assert property ((mode_ff == FCL_NORMAL ##1 mode_ff == FCL_TEST) |-> $past(hold_ms_ff) == 16'(HOLD_MS - 1) && $past(test_lvl))
    else $error("test entered without full hold");
  a_entry_first: assert property ((mode_ff == FCL_NORMAL ##1 mode_ff == FCL_TEST) |-> step_ff == 3'h0 ##1 relay_out.fan == 3'h1)
    else $error("test did not start at speed I");
  a_step_one: assert property ((mode_ff == FCL_TEST && test_press) |=> step_ff == (($past(step_ff) == 3'h6) ? 3'h0 : $past(step_ff) + 3'h1))
    else $error("step not advanced by one");
  a_relay_hold: assert property ((mode_ff == FCL_TEST && step_ff == 3'h1 && !test_press) [*2] |-> relay_out.fan == 3'h2)
    else $error("speed II not held");
  a_idle_restart: assert property ((mode_ff == FCL_TEST && test_press) |=> idle_ms_ff == 16'h0000 && mode_ff == FCL_TEST)
    else $error("idle timer not restarted");
  a_timeout_exit: assert property ((mode_ff == FCL_TEST && tick_ff && !test_press && idle_ms_ff == 16'(IDLE_MS - 1)) |=> mode_ff == FCL_NORMAL ##1 relay_out == '0)
    else $error("timeout did not leave test mode");
  a_pattern_restart: assert property ((mode_ff == FCL_TEST && test_press) |=> slot_n_ff == 4'h0 && slot_ms_ff == 16'h0000)
    else $error("flash pattern not restarted");

  c_enter_test: cover property (mode_ff == FCL_NORMAL ##1 mode_ff == FCL_TEST);
  c_speed_two: cover property (relay_out.fan == 3'h1 ##[1:1000] relay_out.fan == 3'h2);
  c_timeout: cover property (mode_ff == FCL_TEST ##1 mode_ff == FCL_NORMAL);
  c_wrap: cover property (mode_ff == FCL_TEST && step_ff == 3'h6 && test_press);
endmodule
`default_nettype wire
